/* File: rtl/hpc_regs.svh */
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
// Clock rate in kHz
`define HPC_CLK_KHZ 50000
// Duty and drive widths
`define HPC_CNT_W 16
`define HPC_AMP_W 16
// Full-scale signed drive magnitude
`define HPC_FULL_SCALE 16'h7FFF
// A period longer than this many cycles means a static input
`define HPC_STATIC_CYC 16'hFFFF
// Overdrive window figures in ms and derived cycles
`define HPC_OVD_MIN_MS 20
`define HPC_OVD_MAX_MS 50
`define HPC_OVD_MIN_CYC (`HPC_OVD_MIN_MS * `HPC_CLK_KHZ)
`define HPC_OVD_MAX_CYC (`HPC_OVD_MAX_MS * `HPC_CLK_KHZ)
// Duty value that commands no drive
`define HPC_DUTY_MID 16'h8000
// Resonance tracking range in Hz and derived half periods
`define HPC_RES_MIN_HZ 140
`define HPC_RES_MAX_HZ 220
// Half periods count in steps of this many clocks to fit 16 bits
`define HPC_RES_DIV 4
`define HPC_RES_STEP_LAST 2'h3
`define HPC_RES_HALF_MAX \
	((`HPC_CLK_KHZ * 1000) / (2 * `HPC_RES_MIN_HZ * `HPC_RES_DIV))
`define HPC_RES_HALF_MIN \
	((`HPC_CLK_KHZ * 1000) / (2 * `HPC_RES_MAX_HZ * `HPC_RES_DIV))
// Motion estimate decay per resonant half cycle when braking
`define HPC_BRAKE_STEP 16'h0800
`endif

/* File: rtl/hpc_pkg.sv */
package hpc_pkg;
	typedef logic signed [15:0] hpc_amp_t;
	typedef enum logic [1:0] {
		HPC_IDLE  = 2'b00,
		HPC_DRIVE = 2'b01,
		HPC_BRAKE = 2'b11
	} hpc_state_t;
	typedef enum logic [1:0] {
		HPC_H_IDLE  = 2'b00,
		HPC_H_OVD   = 2'b01,
		HPC_H_RUN   = 2'b11,
		HPC_H_BRAKE = 2'b10
	} hpc_host_state_t;
endpackage

/* File: rtl/hpc_link_if.sv */
`timescale 1ns/1ns
interface hpc_link_if;
	logic pwmIn;
	logic enable;
	logic actuatorTypeSelect;
	modport device (input pwmIn, input enable, input actuatorTypeSelect);
	modport host (output pwmIn, output enable, output actuatorTypeSelect);
endinterface

/* File: rtl/hpc_device.sv */
`timescale 1ns/1ns
`include "hpc_regs.svh"
// Behaviour
// [R1] Drive amplitude follows measured input duty
// [R2] Static input gives on/off drive only
// [R3] Rotating mass static: high forward, low reverse
// [R4] Resonant static: high full, low brakes
// [R5] Type select pin picks actuator mode
// [R6] Same effect sequence in both modes
// [R7] Host raises enable with PWM start
// [R8] Host overdrives 20 to 50 ms
// [R9] Host sets zero duty to brake
// [R10] Braking only while enable high
// [R11] Host drops enable after braking
// [R12] Host limits rotating mass brake time
// [R13] Resonant brake stops at zero motion
// [R14] Rotating mass: full, half, zero duty map
// [R15] Resonant below half duty brakes to rest
// [R16] Above half: full scale times (d/50 - 1)
// [R17] Resonance tracked within 140 to 220 Hz; the code holds the half period fixed at the 220 Hz end
// [R18] Enable low: drive off, PWM ignored
// [R19] Duty measured once per PWM period
module hpc_device (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                reset,
	// Link pins
	hpc_link_if.device               link,
	// Drive command to output stage
	output hpc_pkg::hpc_amp_t        driveAmp,
	output logic                     driveActive,
	output logic                     braking,
	output logic [15:0]              resHalfPeriod
);
	import hpc_pkg::*;

	// Three-stage input synchronisers for all pins
	logic [2:0] pwmSync, enSync, selSync;
	logic       pwmLvl, enLvl, selLvl;
	logic       next_pwmLvl, next_enLvl, next_selLvl;
	always_comb begin
		next_pwmLvl = (pwmSync[1] == pwmSync[2]) ? pwmSync[2] : pwmLvl;
		next_enLvl  = (enSync[1] == enSync[2]) ? enSync[2] : enLvl;
		next_selLvl = (selSync[1] == selSync[2]) ? selSync[2] : selLvl;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pwmSync <= 3'h0;
			enSync  <= 3'h0;
			selSync <= 3'h0;
			pwmLvl  <= 1'b0;
			enLvl   <= 1'b0;
			selLvl  <= 1'b0;
		end else begin
			pwmSync <= {pwmSync[1:0], link.pwmIn};
			enSync  <= {enSync[1:0], link.enable};
			selSync <= {selSync[1:0], link.actuatorTypeSelect};
			pwmLvl  <= next_pwmLvl;
			enLvl   <= next_enLvl;
			selLvl  <= next_selLvl; // R5
		end
	end

	// Duty measurement between rising edges
	logic        pwmPrev, next_pwmPrev;
	logic [15:0] perCnt, highCnt, next_perCnt, next_highCnt;
	logic [15:0] duty, next_duty;    // Q0.16 fraction of period
	logic        dutyValid, next_dutyValid;
	logic        rise;
	logic [31:0] quot;
	assign rise = pwmLvl & ~pwmPrev;
	always_comb begin
		next_pwmPrev   = pwmLvl;
		next_perCnt    = perCnt;
		next_highCnt   = highCnt;
		next_duty      = duty;
		next_dutyValid = dutyValid;
		quot           = 32'h0000_0000;
		if (!enLvl) begin
			// Ignore the input while disabled
			next_perCnt    = 16'h0000; // R18
			next_highCnt   = 16'h0000;
			next_dutyValid = 1'b0;
			// Stale duty would kick the next effect; mid-scale is no drive
			next_duty      = `HPC_DUTY_MID; // R1
		end else if (rise && dutyValid && perCnt != 16'h0000) begin
			// One update per period; high time over period
			quot = ({highCnt, 16'h0000}) / {16'h0000, perCnt}; // R19
			next_duty = (quot > 32'h0000_FFFF) ? 16'hFFFF : quot[15:0];
			next_perCnt  = 16'h0001;
			next_highCnt = 16'h0001;
		end else if (rise) begin
			next_dutyValid = 1'b1;
			next_perCnt    = 16'h0001;
			next_highCnt   = 16'h0001;
		end else if (perCnt >= `HPC_STATIC_CYC) begin
			// No edge for too long: static level, on/off use
			next_duty      = pwmLvl ? 16'hFFFF : 16'h0000; // R2
			next_dutyValid = 1'b0;
		end else begin
			next_perCnt  = perCnt + 16'h0001;
			next_highCnt = highCnt + {15'h0000, pwmLvl};
		end
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pwmPrev   <= 1'b0;
			perCnt    <= 16'h0000;
			highCnt   <= 16'h0000;
			duty      <= `HPC_DUTY_MID;
			dutyValid <= 1'b0;
		end else begin
			pwmPrev   <= next_pwmPrev;
			perCnt    <= next_perCnt;
			highCnt   <= next_highCnt;
			duty      <= next_duty;
			dutyValid <= next_dutyValid;
		end
	end

	// Signed command: duty/50 - 1 maps 0..1 onto -FS..+FS
	logic signed [17:0] cmdWide;
	hpc_amp_t           cmd;
	always_comb begin
		cmdWide = $signed({2'b00, duty}) - 18'sh0_8000; // R16 R14
		// Clamped both ways so full reverse mirrors full forward
		cmd = (cmdWide >= 18'sh0_7FFF) ? hpc_amp_t'(`HPC_FULL_SCALE)
		      : (cmdWide <= -18'sh0_7FFF) ? -hpc_amp_t'(`HPC_FULL_SCALE)
		      : hpc_amp_t'(cmdWide[15:0]); // R3 R1
	end

	// Resonance half-period timer and motion estimate
	logic [15:0] resCnt, next_resCnt, next_resHalf;
	logic [15:0] motion, next_motion;
	logic [1:0]  resDiv, next_resDiv;
	logic        resStep, resTick;
	// Half periods count in four-clock steps so the band fits 16 bits
	assign resStep = (resDiv == `HPC_RES_STEP_LAST);
	assign resTick = resStep && (resCnt >= resHalfPeriod);
	hpc_state_t  state, next_state;
	hpc_amp_t    next_driveAmp;
	logic        isResonant;
	assign isResonant = selLvl; // R5 R6

	always_comb begin
		next_state    = state;
		next_driveAmp = 16'sh0000;
		next_resDiv   = resDiv + 2'h1;
		next_resCnt   = resTick ? 16'h0000 :
		                resStep ? resCnt + 16'h0001 : resCnt;
		// Hold the half period, clamped to the resonance band
		next_resHalf  = resHalfPeriod;
		if (`HPC_RES_HALF_MIN > resHalfPeriod) // R17
			next_resHalf = 16'(`HPC_RES_HALF_MIN);
		else if (resHalfPeriod > `HPC_RES_HALF_MAX)
			next_resHalf = 16'(`HPC_RES_HALF_MAX);
		next_motion = motion;
		unique case (state)
			HPC_IDLE: begin
				if (enLvl)
					next_state = HPC_DRIVE;
			end
			HPC_DRIVE: begin
				if (!enLvl) begin
					next_state = HPC_IDLE; // R18
				end else if (!isResonant) begin
					// Negative command is the reverse-drive brake
					next_driveAmp = cmd; // R14
				end else if (cmd <= 16'sh0000) begin
					// Brake drive starts at once, with no zero gap
					next_state    = HPC_BRAKE; // R15 R4
					next_driveAmp = -hpc_amp_t'(motion); // R13
				end else begin
					next_driveAmp = cmd; // R16
					if (cmd > hpc_amp_t'(motion))
						next_motion = cmd[15:0];
				end
			end
			HPC_BRAKE: begin
				if (!enLvl) begin
					next_state = HPC_IDLE; // R10
				end else if (cmd > 16'sh0000) begin
					next_state    = HPC_DRIVE;
					next_driveAmp = cmd; // R16
				end else if (motion == 16'h0000) begin
					next_driveAmp = 16'sh0000; // R13
				end else begin
					// Anti-phase drive no larger than remaining motion
					next_driveAmp = -hpc_amp_t'(motion); // R13
					if (resTick)
						next_motion = (motion > `HPC_BRAKE_STEP) ?
						              motion - `HPC_BRAKE_STEP : 16'h0000;
				end
			end
			default: next_state = HPC_IDLE;
		endcase
		if (!enLvl)
			next_motion = 16'h0000;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state         <= HPC_IDLE;
			driveAmp      <= 16'sh0000;
			resCnt        <= 16'h0000;
			resDiv        <= 2'h0;
			resHalfPeriod <= 16'h0000;
			motion        <= 16'h0000;
		end else begin
			state         <= next_state;
			driveAmp      <= next_driveAmp; // R1
			resCnt        <= next_resCnt;
			resDiv        <= next_resDiv;
			resHalfPeriod <= next_resHalf;
			motion        <= next_motion;
		end
	end

	// Status views for the output stage
	assign driveActive = (state != HPC_IDLE);
	assign braking     = (state == HPC_BRAKE);
endmodule

/* File: rtl/hpc_host.sv */
`timescale 1ns/1ns
`include "hpc_regs.svh"
module hpc_host #(
	parameter int unsigned OVD_CYC   = `HPC_OVD_MIN_CYC,
	parameter int unsigned BRAKE_CYC = `HPC_OVD_MIN_CYC
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// User side
	input  wire logic        start,
	input  wire logic        stop,
	input  wire logic        resonantSel,
	input  wire logic [7:0]  userDuty,
	output logic             busy,
	// Link pins
	hpc_link_if.host         link
);
	import hpc_pkg::*;

	hpc_host_state_t state, next_state;
	logic [31:0]     tmr, next_tmr;
	logic [7:0]      phase, next_phase;
	logic [7:0]      dutySet, next_dutySet;
	logic            pwmOut, next_pwmOut;

	// Sequence and PWM generator
	always_comb begin
		next_state   = state;
		next_tmr     = tmr;
		next_dutySet = dutySet;
		next_phase   = phase + 8'h01;
		unique case (state)
			HPC_H_IDLE: begin
				if (start) begin
					// Enable and PWM rise together, full overdrive
					next_state   = HPC_H_OVD; // R7
					next_dutySet = 8'hFF;
					next_tmr     = 32'h0000_0000;
					next_phase   = 8'h00;
				end
			end
			HPC_H_OVD: begin
				next_tmr = tmr + 32'h0000_0001;
				if (tmr + 32'h0000_0001 >= OVD_CYC) begin
					next_state = HPC_H_RUN; // R8
					next_dutySet = userDuty;
				end
			end
			HPC_H_RUN: begin
				next_dutySet = userDuty;
				if (stop) begin
					next_state   = HPC_H_BRAKE;
					next_dutySet = 8'h00; // R9
					next_tmr     = 32'h0000_0000;
				end
			end
			HPC_H_BRAKE: begin
				// Enable stays high; braking time is bounded
				next_tmr = tmr + 32'h0000_0001; // R10 R12
				if (tmr + 32'h0000_0001 >= BRAKE_CYC)
					next_state = HPC_H_IDLE; // R11
			end
		endcase
		// From the next values, so PWM rises on the edge enable does
		next_pwmOut = (next_state != HPC_H_IDLE) && // R7
		              ((next_dutySet == 8'hFF) ||
		               (next_phase < next_dutySet));
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state   <= HPC_H_IDLE;
			tmr     <= 32'h0000_0000;
			phase   <= 8'h00;
			dutySet <= 8'h00;
			pwmOut  <= 1'b0;
		end else begin
			state   <= next_state;
			tmr     <= next_tmr;
			phase   <= next_phase;
			dutySet <= next_dutySet;
			pwmOut  <= next_pwmOut;
		end
	end

	assign link.pwmIn  = pwmOut;
	assign link.enable = (state != HPC_H_IDLE); // R7 R11
	assign link.actuatorTypeSelect = resonantSel; // R5 R6
	assign busy = (state != HPC_H_IDLE);
endmodule

/* File: sim/hpc_link_monitor.sv */
`timescale 1ns/1ns
module hpc_link_monitor (
	// Clock and reset
	input wire logic              core_clk,
	input wire logic              reset,
	// Link pins
	input wire logic              pwmIn,
	input wire logic              enable,
	input wire logic              actuatorTypeSelect,
	// Device drive
	input wire hpc_pkg::hpc_amp_t driveAmp,
	input wire logic              driveActive,
	input wire logic              braking
);
	import hpc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Six low cycles cover the pin sync delay
	drive_off_a: assert property (
		!enable [*6] |-> driveAmp == 0) else $error("drive not off");
	active_off_a: assert property (
		!enable [*6] |-> !driveActive) else $error("active not off");
	brake_en_a: assert property (
		!enable [*6] |-> !braking) else $error("brake without enable");
	// Type select may not move inside an effect
	type_static_a: assert property (
		enable && $past(enable) |-> $stable(actuatorTypeSelect))
		else $error("type select moved");
	// A new command stands for at least three cycles after it changes
	amp_hold_a: assert property (
		$changed(driveAmp) && enable |=> $stable(driveAmp) [*3])
		else $error("amplitude not held");
	amp_clear_a: assert property (
		$fell(driveActive) |-> ##[0:2] driveAmp == 0)
		else $error("amplitude left over");
	start_ovd_a: assert property (
		$rose(enable) |-> pwmIn [*8]) else $error("no overdrive at start");
	end_brake_a: assert property (
		$fell(enable) |-> !$past(pwmIn) && !$past(pwmIn, 8))
		else $error("enable dropped without zero duty");
	cover property ($rose(enable) && actuatorTypeSelect);
	cover property ($rose(braking));
	cover property ($fell(enable) && !actuatorTypeSelect);
endmodule

/* File: sim/haptic_pwm_command_control_tb.sv */
`timescale 1ns/1ns
`include "hpc_regs.svh"
module haptic_pwm_command_control_tb;
	import hpc_pkg::*;
	localparam int FS = `HPC_FULL_SCALE;
	logic        core_clk = 0;
	logic        reset = 1;
	logic        start = 0;
	logic        stop = 0;
	logic        resonantSel = 0;
	logic [7:0]  userDuty = 8'h80;
	logic        busy, driveActive, braking, prev = 0;
	hpc_amp_t    driveAmp;
	logic [15:0] resHalf;
	logic [31:0] rnd = 32'h561d_e6dd;
	int          fail_count = 0, num_checks = 0;
	int          hi, per, edges, cnt, hiAcc;
	hpc_link_if link ();
	hpc_host #(.OVD_CYC(50), .BRAKE_CYC(50)) u_hpc_host (.core_clk(core_clk),
		.reset(reset), .start(start), .stop(stop), .resonantSel(resonantSel),
		.userDuty(userDuty), .busy(busy), .link(link.host));
	hpc_device u_hpc_device (.core_clk(core_clk), .reset(reset),
		.link(link.device), .driveAmp(driveAmp), .driveActive(driveActive),
		.braking(braking), .resHalfPeriod(resHalf));
	hpc_link_monitor u_mon (.core_clk(core_clk), .reset(reset),
		.pwmIn(link.pwmIn), .enable(link.enable),
		.actuatorTypeSelect(link.actuatorTypeSelect), .driveAmp(driveAmp),
		.driveActive(driveActive), .braking(braking));
	// Free-running clock
	always #10 core_clk = ~core_clk;
	// Wire model: high time and length of each finished PWM period
	always @(posedge core_clk) begin
		if (link.pwmIn === 1'b1 && !prev) begin
			hi = hiAcc;
			per = cnt;
			edges++;
			cnt = 0;
			hiAcc = 0;
		end
		cnt++;
		if (link.pwmIn === 1'b1) hiAcc++;
		prev = link.pwmIn === 1'b1;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic give_up;
		fail_count++;
		tally_and_finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Quantisation of one count in a period bounds the tolerance
	task automatic chk_amp(input hpc_amp_t got, input int exp, input int tol);
		int d;
		d = int'(got) - exp;
		num_checks++;
		if (^got === 1'bx || d > tol || d < -tol) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic waitp(input int n);
		int k, e0;
		e0 = edges;
		k = 0;
		while (edges < e0 + n && k < 20000) begin
			@(negedge core_clk);
			k++;
		end
		if (edges < e0 + n) give_up;
	endtask
	// Stop, let the host brake and release, then all must be idle
	task automatic end_effect(input logic revChk);
		int k;
		stop = 1;
		@(negedge core_clk);
		stop = 0;
		if (revChk) begin
			repeat (20) @(negedge core_clk);
			chk_amp(driveAmp, -FS, 0);
		end
		k = 0;
		while (busy !== 1'b0 && k < 2000) begin
			@(negedge core_clk);
			k++;
		end
		if (busy !== 1'b0) give_up;
		repeat (8) @(negedge core_clk);
		chk_bit(driveActive, 1'b0);
		chk_bit(braking, 1'b0);
		chk_amp(driveAmp, 0, 0);
	endtask
	// Constant input: on/off use, full forward then full reverse
	task automatic static_effect;
		resonantSel = 1'b0;
		userDuty = 8'hFF;
		@(negedge core_clk);
		start = 1;
		@(negedge core_clk);
		start = 0;
		repeat (`HPC_STATIC_CYC + 64) @(negedge core_clk);
		chk_amp(driveAmp, FS, 0);
		chk_bit(resHalf >= `HPC_RES_HALF_MIN &&
		        resHalf <= `HPC_RES_HALF_MAX, 1'b1);
		end_effect(1'b1);
	endtask
	// One whole effect: start, random duties, stop, brake, release
	task automatic effect(input logic sel);
		int i, e, k;
		resonantSel = sel;
		@(negedge core_clk);
		start = 1;
		@(negedge core_clk);
		start = 0;
		for (i = 0; i < 6; i++) begin
			rnd = xs(rnd);
			userDuty = (sel || !i[0]) ? 8'h8c + 8'(rnd % 100)
				: 8'h14 + 8'(rnd % 90);
			waitp(4);
			e = FS * (2 * hi - per) / per;
			k = 131072 / per + 64;
			if (sel) chk_amp(driveAmp < 0 ? -driveAmp : driveAmp, e, k);
			else chk_amp(driveAmp, e, k);
		end
		if (sel) begin
			userDuty = 8'h40;
			waitp(4);
			chk_bit(braking, 1'b1);
		end
		end_effect(1'b0);
	endtask
	// Main sequence: both actuator modes and back
	initial begin
		repeat (16) @(negedge core_clk);
		reset = 0;
		effect(1'b0);
		effect(1'b1);
		effect(1'b0);
		static_effect;
		tally_and_finish;
	end
endmodule
